// >>> logic/dls_pkg.sv
// Constants, types and carriers for the drive limit supervisor
package dls_pkg;
    // Parameter addresses
    localparam logic [15:0] ADR_FE_REACT = 16'h0516;
    localparam logic [15:0] ADR_SYM_RAMP = 16'h0602;
    localparam logic [15:0] ADR_SL_EN = 16'h0606;
    localparam logic [15:0] ADR_SL_POS = 16'h0608;
    localparam logic [15:0] ADR_SL_NEG = 16'h060a;
    localparam logic [15:0] ADR_SPD_LIM = 16'h0612;
    localparam logic [15:0] ADR_ACC = 16'h0614;
    localparam logic [15:0] ADR_DEC = 16'h0616;
    localparam logic [15:0] ADR_QS_DEC = 16'h0624;
    localparam logic [15:0] ADR_SS_BAND = 16'h1112;
    localparam logic [15:0] ADR_SS_DWELL = 16'h1114;
    localparam logic [15:0] ADR_SS_TOUT = 16'h1116;
    localparam logic [15:0] ADR_STATUS = 16'h1118;
    localparam logic [15:0] ADR_FE_LIM = 16'h121c;
    localparam logic [15:0] ADR_SPD_SRC = 16'h1b22;
    localparam logic [15:0] ADR_SPD_SET = 16'h2108;
    // Reset values and ranges
    localparam logic [1:0] FE_REACT_RST = 2'h3;
    localparam logic [1:0] FE_REACT_MIN = 2'h1;
    localparam logic [31:0] SL_POS_RST = 32'h7fffffff;
    localparam logic [31:0] SL_NEG_RST = 32'h80000000;
    localparam logic signed [31:0] USR_MAX = 32'sh7fffffff;
    localparam logic signed [31:0] USR_MIN = 32'sh80000000;
    localparam logic [31:0] SPD_LIM_RST = 32'h00003390;
    localparam logic [31:0] SPD_LIM_MIN = 32'h0000003c;
    localparam logic [31:0] SPD_LIM_MAX = 32'h00003390;
    localparam logic [31:0] ACC_RST = 32'h00000258;
    localparam logic [31:0] ACC_MIN = 32'h00000001;
    localparam logic [31:0] DEC_RST = 32'h000002ee;
    localparam logic [31:0] DEC_MIN = 32'h000002ee;
    localparam logic [31:0] RAMP_MAX = 32'h002dc6c0;
    localparam logic [31:0] QS_RST = 32'h00001770;
    localparam logic [31:0] QS_MIN = 32'h000000c8;
    localparam logic [31:0] RAMP_UNIT = 32'h0000000a;
    localparam logic [31:0] SS_BAND_RST = 32'h0000000a;
    localparam logic [31:0] SS_BAND_MAX = 32'h00007fff;
    localparam logic [31:0] SS_DWELL_MAX = 32'h00007fff;
    localparam logic [31:0] SS_TOUT_MAX = 32'h00003e80;
    localparam logic [31:0] FE_LIM_RST = 32'h00002710;
    localparam logic [31:0] FE_LIM_MIN = 32'h00000001;
    localparam logic [31:0] FE_LIM_MAX = 32'h001e8480;
    localparam logic signed [15:0] SPD_SET_MAX = 16'sh7530;
    localparam logic signed [15:0] SPD_SET_MIN = -16'sh7530;
    localparam logic [1:0] SRC_PARAM = 2'h2;
    // Status word bit positions
    localparam int ST_TOUT_BIT = 0;
    localparam int ST_STAND_BIT = 1;
    localparam int ST_FE_BIT = 2;
    // Millisecond timing
    localparam int CLK_MHZ = 100;
    localparam int MS_IN_US = 1000;
    localparam int CYC_PER_MS = CLK_MHZ * MS_IN_US;
    // Operating modes
    typedef enum logic [2:0] {
        MODE_NONE = 3'h0, MODE_PPOS = 3'h1, MODE_PVEL = 3'h2,
        MODE_HOME = 3'h3, MODE_JOG = 3'h4, MODE_SPEED = 3'h5
    } mode_type;
    // Parameter access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } par_req_type;
    // Parameter access answer
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } par_rsp_type;
endpackage

// >>> logic/drive_limit_supervisor.sv
// Supervision and limiting of speed, ramps, tracking and standstill
module drive_limit_supervisor #(
    parameter int MS_CYCLES = dls_pkg::CYC_PER_MS
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // Fieldbus parameter access
    input wire dls_pkg::par_req_type PAR_REQ_I,
    output dls_pkg::par_rsp_type PAR_RSP_O,
    // Motion inputs
    input wire dls_pkg::mode_type MODE_I,
    input wire logic [31:0] REQ_SPEED_I,
    input wire logic SW_STOP_I,
    input wire logic ERR_CLASS1_I,
    input wire logic signed [15:0] CTRL_SPEED_CEIL_I,
    input wire logic signed [31:0] POS_DEV_I,
    input wire logic signed [31:0] ACT_POS_I,
    input wire logic HOMING_DONE_I,
    input wire logic TARGET_REACHED_I,
    input wire logic PROFILE_DONE_I,
    // Limited references and ramps
    output logic [31:0] REF_SPEED_O,
    output logic [31:0] ACC_RATE_O,
    output logic [31:0] DEC_RATE_O,
    output logic QUICK_STOP_O,
    output logic signed [15:0] SPEED_CTRL_REF_O,
    // Supervision results
    output logic FOLLOW_ERR_O,
    output logic [1:0] FOLLOW_ERR_CLASS_O,
    output logic LIMIT_POS_HIT_O,
    output logic LIMIT_NEG_HIT_O,
    output logic STANDSTILL_O,
    output logic STANDSTILL_TOUT_O
);
    import dls_pkg::*;

    // Clamp an unsigned value into a range
    function automatic logic [31:0] clampu(input logic [31:0] v, input logic [31:0] lo,
                                           input logic [31:0] hi);
        clampu = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Magnitude of a signed deviation, saturated to positive range
    function automatic logic [31:0] magn(input logic signed [31:0] v);
        magn = v[31] ? ((v == USR_MIN) ? 32'h7fffffff : 32'(-v)) : 32'(v);
    endfunction

    // Parameter registers
    logic [1:0] fe_react_ff; // Tracking error class
    logic [1:0] sl_en_ff; // Soft limit direction enables
    logic signed [31:0] sl_pos_ff; // Positive soft limit
    logic signed [31:0] sl_neg_ff; // Negative soft limit
    logic [31:0] spd_lim_ff; // Profile speed ceiling
    logic [31:0] acc_ff; // Profile acceleration
    logic [31:0] dec_ff; // Profile deceleration
    logic [31:0] qs_ff; // Quick-stop deceleration
    logic [15:0] ss_band_ff; // Standstill band
    logic [15:0] ss_dwell_ff; // Standstill dwell in ms
    logic [15:0] ss_tout_ff; // Standstill timeout in ms
    logic [31:0] fe_lim_ff; // Tracking error limit
    logic [1:0] spd_src_ff; // Speed control source
    logic signed [15:0] spd_set_ff; // Speed control setpoint
    logic tout_flag_ff; // Sticky standstill timeout flag

    // Access decode
    logic wr; // Write strobe
    logic [31:0] wd; // Write data
    logic signed [31:0] wds; // Write data as signed
    logic [31:0] ramp_wr; // Symmetric ramp scaled to rate units
    logic [31:0] ramp_big; // Larger of the two ramps
    logic [31:0] ramp_rd; // Ramp in readback units
    assign wr = PAR_REQ_I.wr;
    assign wd = PAR_REQ_I.wdata;
    assign wds = PAR_REQ_I.wdata;
    assign ramp_wr = {16'h0000, wd[15:0]} * RAMP_UNIT;
    assign ramp_big = (acc_ff > dec_ff) ? acc_ff : dec_ff;
    assign ramp_rd = ramp_big / RAMP_UNIT;

    // Class, soft limit enable and source registers
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            fe_react_ff <= FE_REACT_RST;
            sl_en_ff <= 2'h0;
            spd_src_ff <= 2'h0;
        end else if (wr) begin
            // Illegal codes are refused so the old setting stays valid
            if (PAR_REQ_I.addr == ADR_FE_REACT && wd[15:0] >= 16'(FE_REACT_MIN)
                && wd[15:0] <= 16'(FE_REACT_RST)) begin
                fe_react_ff <= wd[1:0];
            end
            if (PAR_REQ_I.addr == ADR_SL_EN && wd[15:0] <= 16'h0003) begin
                sl_en_ff <= wd[1:0];
            end
            if (PAR_REQ_I.addr == ADR_SPD_SRC && (wd[15:0] == 16'h0000
                || wd[15:0] == 16'(SRC_PARAM))) begin
                spd_src_ff <= wd[1:0];
            end
        end
    end

    // Soft limit positions
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            sl_pos_ff <= SL_POS_RST;
            sl_neg_ff <= SL_NEG_RST;
        end else if (wr) begin
            // Values past the user range fall back to the user maximum
            if (PAR_REQ_I.addr == ADR_SL_POS) begin
                sl_pos_ff <= (wds > USR_MAX || wds < USR_MIN) ? USR_MAX : wds;
            end
            if (PAR_REQ_I.addr == ADR_SL_NEG) begin
                sl_neg_ff <= (wds > USR_MAX || wds < USR_MIN) ? USR_MAX : wds;
            end
        end
    end

    // Speed limit, ramps and quick stop
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            spd_lim_ff <= SPD_LIM_RST;
            acc_ff <= ACC_RST;
            dec_ff <= DEC_RST;
            qs_ff <= QS_RST;
        end else if (wr) begin
            if (PAR_REQ_I.addr == ADR_SPD_LIM) begin
                spd_lim_ff <= clampu({16'h0000, wd[15:0]}, SPD_LIM_MIN, SPD_LIM_MAX);
            end
            if (PAR_REQ_I.addr == ADR_QS_DEC) begin
                qs_ff <= clampu(wd, QS_MIN, RAMP_MAX);
            end
            // One symmetric write moves both ramps, each into its own range
            if (PAR_REQ_I.addr == ADR_SYM_RAMP) begin
                acc_ff <= clampu(ramp_wr, ACC_MIN, RAMP_MAX);
                dec_ff <= clampu(ramp_wr, DEC_MIN, RAMP_MAX);
            end
            if (PAR_REQ_I.addr == ADR_ACC) begin
                acc_ff <= clampu(wd, ACC_MIN, RAMP_MAX);
            end
            if (PAR_REQ_I.addr == ADR_DEC) begin
                dec_ff <= clampu(wd, DEC_MIN, RAMP_MAX);
            end
        end
    end

    // Standstill, tracking and speed setpoint parameters
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            ss_band_ff <= SS_BAND_RST[15:0];
            ss_dwell_ff <= 16'h0000;
            ss_tout_ff <= 16'h0000;
            fe_lim_ff <= FE_LIM_RST;
            spd_set_ff <= 16'sh0000;
        end else if (wr) begin
            if (PAR_REQ_I.addr == ADR_SS_BAND) begin
                ss_band_ff <= 16'(clampu({16'h0000, wd[15:0]}, 32'h0, SS_BAND_MAX));
            end
            if (PAR_REQ_I.addr == ADR_SS_DWELL) begin
                ss_dwell_ff <= 16'(clampu({16'h0000, wd[15:0]}, 32'h0, SS_DWELL_MAX));
            end
            if (PAR_REQ_I.addr == ADR_SS_TOUT) begin
                ss_tout_ff <= 16'(clampu({16'h0000, wd[15:0]}, 32'h0, SS_TOUT_MAX));
            end
            if (PAR_REQ_I.addr == ADR_FE_LIM) begin
                fe_lim_ff <= clampu(wd, FE_LIM_MIN, FE_LIM_MAX);
            end
            if (PAR_REQ_I.addr == ADR_SPD_SET) begin
                spd_set_ff <= ($signed(wds[15:0]) > SPD_SET_MAX) ? SPD_SET_MAX
                    : (($signed(wds[15:0]) < SPD_SET_MIN) ? SPD_SET_MIN : wds[15:0]);
            end
        end
    end

    // Readback mux, unmapped addresses answer with an error
    logic [31:0] rd_val; // Selected read value
    logic rd_hit; // Address is mapped
    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0;
        case (PAR_REQ_I.addr)
            ADR_FE_REACT: rd_val = {30'h0, fe_react_ff};
            ADR_SYM_RAMP: rd_val = (ramp_rd > 32'h0000ffff) ? 32'h0000ffff : ramp_rd;
            ADR_SL_EN: rd_val = {30'h0, sl_en_ff};
            ADR_SL_POS: rd_val = sl_pos_ff;
            ADR_SL_NEG: rd_val = sl_neg_ff;
            ADR_SPD_LIM: rd_val = spd_lim_ff;
            ADR_ACC: rd_val = acc_ff;
            ADR_DEC: rd_val = dec_ff;
            ADR_QS_DEC: rd_val = qs_ff;
            ADR_SS_BAND: rd_val = {16'h0, ss_band_ff};
            ADR_SS_DWELL: rd_val = {16'h0, ss_dwell_ff};
            ADR_SS_TOUT: rd_val = {16'h0, ss_tout_ff};
            ADR_STATUS: rd_val = {29'h0, FOLLOW_ERR_O, STANDSTILL_O, tout_flag_ff};
            ADR_FE_LIM: rd_val = fe_lim_ff;
            ADR_SPD_SRC: rd_val = {30'h0, spd_src_ff};
            ADR_SPD_SET: rd_val = {{16{spd_set_ff[15]}}, spd_set_ff};
            default: rd_hit = 1'b0;
        endcase
    end

    // Registered answer one cycle after each access
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            PAR_RSP_O <= '0;
        end else begin
            PAR_RSP_O.ack <= PAR_REQ_I.wr | PAR_REQ_I.rd;
            PAR_RSP_O.err <= (PAR_REQ_I.wr | PAR_REQ_I.rd) & ~rd_hit;
            PAR_RSP_O.rdata <= PAR_REQ_I.rd ? rd_val : 32'h0;
        end
    end

    // Reference speed, ramp and speed control outputs
    logic profile_mode; // Mode uses the profile generator
    logic signed [15:0] ceil_mag; // Controller ceiling magnitude
    assign profile_mode = (MODE_I == MODE_PPOS) || (MODE_I == MODE_PVEL)
        || (MODE_I == MODE_HOME) || (MODE_I == MODE_JOG);
    assign ceil_mag = CTRL_SPEED_CEIL_I[15] ? -CTRL_SPEED_CEIL_I : CTRL_SPEED_CEIL_I;
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            REF_SPEED_O <= 32'h0;
            ACC_RATE_O <= ACC_RST;
            DEC_RATE_O <= DEC_RST;
            QUICK_STOP_O <= 1'b0;
            SPEED_CTRL_REF_O <= 16'sh0000;
        end else begin
            REF_SPEED_O <= (profile_mode && REQ_SPEED_I > spd_lim_ff) ? spd_lim_ff : REQ_SPEED_I;
            ACC_RATE_O <= acc_ff;
            QUICK_STOP_O <= SW_STOP_I | ERR_CLASS1_I;
            DEC_RATE_O <= (SW_STOP_I | ERR_CLASS1_I) ? qs_ff : dec_ff;
            // Source 0 leaves the speed loop without a reference
            if (spd_src_ff != SRC_PARAM) begin
                SPEED_CTRL_REF_O <= 16'sh0000;
            end else if (spd_set_ff > ceil_mag) begin
                SPEED_CTRL_REF_O <= ceil_mag;
            end else if (spd_set_ff < -ceil_mag) begin
                SPEED_CTRL_REF_O <= -ceil_mag;
            end else begin
                SPEED_CTRL_REF_O <= spd_set_ff;
            end
        end
    end

    // Tracking error and soft limit supervision
    logic [31:0] dev_mag; // Magnitude of control deviation
    assign dev_mag = magn(POS_DEV_I);
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            FOLLOW_ERR_O <= 1'b0;
            FOLLOW_ERR_CLASS_O <= 2'h0;
            LIMIT_POS_HIT_O <= 1'b0;
            LIMIT_NEG_HIT_O <= 1'b0;
        end else begin
            FOLLOW_ERR_O <= dev_mag > fe_lim_ff;
            FOLLOW_ERR_CLASS_O <= (dev_mag > fe_lim_ff) ? fe_react_ff : 2'h0;
            // Positions are meaningless before homing, so no check then
            LIMIT_POS_HIT_O <= HOMING_DONE_I && sl_en_ff[0] && ACT_POS_I > sl_pos_ff;
            LIMIT_NEG_HIT_O <= HOMING_DONE_I && sl_en_ff[1] && ACT_POS_I < sl_neg_ff;
        end
    end

    // Millisecond tick shared by dwell and timeout timers
    logic [31:0] ms_cnt_ff; // Cycle count within a millisecond
    logic ms_tick; // One-cycle millisecond pulse
    assign ms_tick = (ms_cnt_ff == 32'(MS_CYCLES - 1));
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            ms_cnt_ff <= 32'h0;
        end else begin
            ms_cnt_ff <= ms_tick ? 32'h0 : ms_cnt_ff + 32'h1;
        end
    end

    // Standstill dwell: deviation must stay in band for whole dwell
    logic [15:0] dwell_ff; // Milliseconds spent in band
    logic in_band; // Deviation within standstill band
    assign in_band = dev_mag <= {16'h0, ss_band_ff};
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            dwell_ff <= 16'h0;
            STANDSTILL_O <= 1'b0;
        end else if (ss_dwell_ff == 16'h0 || !in_band) begin
            // Leaving the band restarts the whole dwell
            dwell_ff <= 16'h0;
            STANDSTILL_O <= 1'b0;
        end else begin
            if (ms_tick && dwell_ff < ss_dwell_ff) begin
                dwell_ff <= dwell_ff + 16'h1;
            end
            STANDSTILL_O <= dwell_ff >= ss_dwell_ff;
        end
    end

    // Standstill timeout state machine
    typedef enum logic [1:0] {TO_IDLE = 2'b01, TO_RUN = 2'b10} tout_state_type;
    tout_state_type tst_ff; // Timeout state
    logic [15:0] tout_cnt_ff; // Milliseconds since start
    logic tout_clr; // Software clear of the timeout flag
    logic tout_set; // Timeout expired this cycle
    assign tout_clr = wr && PAR_REQ_I.addr == ADR_STATUS && wd[ST_TOUT_BIT];
    assign tout_set = tst_ff == TO_RUN && ss_tout_ff != 16'h0 && !STANDSTILL_O && tout_cnt_ff >= ss_tout_ff;
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            tst_ff <= TO_IDLE;
            tout_cnt_ff <= 16'h0;
        end else begin
            case (tst_ff)
                TO_IDLE: begin
                    tout_cnt_ff <= 16'h0;
                    // A zero timeout never arms the timer
                    if ((TARGET_REACHED_I || PROFILE_DONE_I) && ss_tout_ff != 16'h0) begin
                        tst_ff <= TO_RUN;
                    end
                end
                TO_RUN: begin
                    if (ss_tout_ff == 16'h0 || STANDSTILL_O || tout_set) begin
                        tst_ff <= TO_IDLE;
                    end else if (ms_tick) begin
                        tout_cnt_ff <= tout_cnt_ff + 16'h1;
                    end
                end
                default: tst_ff <= TO_IDLE;
            endcase
        end
    end

    // Sticky timeout flag, a new expiry wins over a clear
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            tout_flag_ff <= 1'b0;
        end else if (tout_set) begin
            tout_flag_ff <= 1'b1;
        end else if (tout_clr) begin
            tout_flag_ff <= 1'b0;
        end
    end
    assign STANDSTILL_TOUT_O = tout_flag_ff;
endmodule

// >>> sim/drive_limit_supervisor_props.sv
// Port-level checker for the drive limit supervisor
module drive_limit_supervisor_props #(
    parameter int MS_CYCLES = dls_pkg::CYC_PER_MS
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // Parameter bus
    input wire dls_pkg::par_req_type PAR_REQ_I,
    input wire dls_pkg::par_rsp_type PAR_RSP_O,
    // Motion inputs
    input wire dls_pkg::mode_type MODE_I,
    input wire logic [31:0] REQ_SPEED_I,
    input wire logic SW_STOP_I,
    input wire logic ERR_CLASS1_I,
    input wire logic signed [31:0] POS_DEV_I,
    input wire logic HOMING_DONE_I,
    // Watched outputs
    input wire logic [31:0] REF_SPEED_O,
    input wire logic QUICK_STOP_O,
    input wire logic signed [15:0] SPEED_CTRL_REF_O,
    input wire logic FOLLOW_ERR_O,
    input wire logic [1:0] FOLLOW_ERR_CLASS_O,
    input wire logic LIMIT_POS_HIT_O,
    input wire logic LIMIT_NEG_HIT_O,
    input wire logic STANDSTILL_TOUT_O
);
    import dls_pkg::*;
    // Any request strobe on the bus
    wire logic req_any = PAR_REQ_I.wr || PAR_REQ_I.rd;
    // A status write that clears the timeout flag
    wire logic clr_req = PAR_REQ_I.wr && (PAR_REQ_I.addr == ADR_STATUS) && PAR_REQ_I.wdata[0];
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    a_ack_after_req: assert property (req_any |=> PAR_RSP_O.ack) else $error("access not answered");
    a_no_stray_ack: assert property (!req_any |=> !PAR_RSP_O.ack) else $error("answer without access");
    a_ref_clamped: assert property ((MODE_I inside {MODE_PPOS, MODE_PVEL, MODE_HOME, MODE_JOG}) |=>
        (REF_SPEED_O <= 32'h3390) && (REF_SPEED_O <= $past(REQ_SPEED_I))) else $error("speed not clamped");
    a_quick_stop_cause: assert property (1'b1 |=> QUICK_STOP_O == $past(SW_STOP_I || ERR_CLASS1_I))
        else $error("quick stop does not follow its causes");
    a_setpoint_range: assert property ((SPEED_CTRL_REF_O <= 16'sh7530) && (SPEED_CTRL_REF_O >= -16'sh7530))
        else $error("speed reference out of range");
    a_limits_need_homing: assert property (!HOMING_DONE_I |=> !LIMIT_POS_HIT_O && !LIMIT_NEG_HIT_O)
        else $error("limit hit without homing");
    a_fe_class_legal: assert property (FOLLOW_ERR_O ? FOLLOW_ERR_CLASS_O != 2'h0 : FOLLOW_ERR_CLASS_O == 2'h0)
        else $error("reaction class inconsistent");
    a_fe_zero_dev: assert property (POS_DEV_I == 32'sh0 |=> !FOLLOW_ERR_O) else $error("error at zero deviation");
    a_tout_sticky: assert property (STANDSTILL_TOUT_O && !clr_req && !$past(clr_req) |=> STANDSTILL_TOUT_O)
        else $error("timeout flag dropped");
endmodule
bind drive_limit_supervisor drive_limit_supervisor_props #(.MS_CYCLES(MS_CYCLES)) u_props (
    .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .PAR_REQ_I(PAR_REQ_I), .PAR_RSP_O(PAR_RSP_O), .MODE_I(MODE_I),
    .REQ_SPEED_I(REQ_SPEED_I), .SW_STOP_I(SW_STOP_I), .ERR_CLASS1_I(ERR_CLASS1_I), .POS_DEV_I(POS_DEV_I),
    .HOMING_DONE_I(HOMING_DONE_I), .REF_SPEED_O(REF_SPEED_O), .QUICK_STOP_O(QUICK_STOP_O),
    .SPEED_CTRL_REF_O(SPEED_CTRL_REF_O), .FOLLOW_ERR_O(FOLLOW_ERR_O), .FOLLOW_ERR_CLASS_O(FOLLOW_ERR_CLASS_O),
    .LIMIT_POS_HIT_O(LIMIT_POS_HIT_O), .LIMIT_NEG_HIT_O(LIMIT_NEG_HIT_O), .STANDSTILL_TOUT_O(STANDSTILL_TOUT_O));

// >>> sim/fieldbus_master_model.sv
// Fieldbus master model issuing one-word parameter accesses
module fieldbus_master_model (
    // Clock
    input wire logic CLK_I,
    // Answer from the drive
    input wire dls_pkg::par_rsp_type PAR_RSP_I,
    // Request to the drive
    output dls_pkg::par_req_type PAR_REQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    import dls_pkg::*;
    initial PAR_REQ_O = '0;
    // One-cycle strobe, then a bounded wait for the answer
    task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n = 0;
        @(negedge CLK_I);
        PAR_REQ_O = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge CLK_I);
        // Released strobes drop to zero, address and data show inverted values, never the old ones
        PAR_REQ_O = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        while (PAR_RSP_I.ack !== 1'b1 && n < 4) begin
            @(negedge CLK_I);
            n++;
        end
    endtask
endmodule

// >>> sim/drive_limit_supervisor_tb.sv
// Self-checking bench for the drive limit supervisor
module drive_limit_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dls_pkg::*;
    // Stimulus, outputs and bookkeeping
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    par_req_type req;
    par_rsp_type rsp;
    mode_type mode = MODE_NONE;
    logic [31:0] spd = 32'h0;
    logic stop = 1'b0, cls1 = 1'b0, homed = 1'b0, tgt = 1'b0, pdone = 1'b0;
    logic signed [15:0] ceil = 16'sh7fff;
    logic signed [31:0] dev = 32'sh0, pos = 32'sh0;
    logic [31:0] ref_o, acc_o, dec_o;
    logic qs_o, fe_o, lp_o, ln_o, ss_o, to_o;
    logic signed [15:0] sref_o;
    logic [1:0] cls_o;
    par_rsp_type exp_q[$];
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    // Short millisecond so the timers finish quickly
    drive_limit_supervisor #(.MS_CYCLES(10)) u_drive_limit_supervisor (
        .CLK_I(clk), .RESET_N_I(rst_n), .PAR_REQ_I(req), .PAR_RSP_O(rsp), .MODE_I(mode),
        .REQ_SPEED_I(spd), .SW_STOP_I(stop), .ERR_CLASS1_I(cls1), .CTRL_SPEED_CEIL_I(ceil),
        .POS_DEV_I(dev), .ACT_POS_I(pos), .HOMING_DONE_I(homed), .TARGET_REACHED_I(tgt),
        .PROFILE_DONE_I(pdone), .REF_SPEED_O(ref_o), .ACC_RATE_O(acc_o), .DEC_RATE_O(dec_o),
        .QUICK_STOP_O(qs_o), .SPEED_CTRL_REF_O(sref_o), .FOLLOW_ERR_O(fe_o), .FOLLOW_ERR_CLASS_O(cls_o),
        .LIMIT_POS_HIT_O(lp_o), .LIMIT_NEG_HIT_O(ln_o), .STANDSTILL_O(ss_o), .STANDSTILL_TOUT_O(to_o));
    fieldbus_master_model u_fieldbus_master_model (.CLK_I(clk), .PAR_RSP_I(rsp), .PAR_REQ_O(req));
    // Level result compare
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        checks++;
        if (got !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, e, got);
        end
    endtask
    // Bus answer compare
    task automatic chk_rsp(input par_rsp_type e);
        checks++;
        if (rsp !== e) begin
            mismatches++;
            $display("FAIL answer expected %h seen %h", e, rsp);
        end
    endtask
    // Accesses note their expected answer before going out
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        exp_q.push_back('{1'b1, 1'b0, 32'h0});
        u_fieldbus_master_model.access(1'b1, a, d);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic e = 1'b0);
        exp_q.push_back('{1'b1, e, d});
        u_fieldbus_master_model.access(1'b0, a, 32'h0);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Bounded wait for standstill (0) or timeout flag (1)
    task automatic wait_flag(input bit sel);
        int n = 0;
        while ((sel ? to_o : ss_o) !== 1'b1 && n < 80) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic tally_and_finish();
        // Notes never answered count as one mismatch
        if (exp_q.size() != 0)
            mismatches++;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Every answer takes the oldest note; an unexpected one compares against zero
    always @(negedge clk) begin
        if (rsp.ack === 1'b1)
            chk_rsp(exp_q.size() != 0 ? exp_q.pop_front() : '0);
    end
    // Hang guard, well above the few hundred cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        logic [31:0] r;
        r = $urandom(97);
        cyc(4);
        rst_n = 1'b1;
        chk("acc", 32'h258, acc_o);
        chk("dec", 32'h2ee, dec_o);
        rd(ADR_FE_REACT, 32'h3);
        rd(ADR_SYM_RAMP, 32'h4b);
        rd(ADR_SL_POS, 32'h7fffffff);
        rd(ADR_SL_NEG, 32'h80000000);
        rd(ADR_SPD_LIM, 32'h3390);
        rd(ADR_QS_DEC, 32'h1770);
        rd(ADR_SS_BAND, 32'ha);
        rd(ADR_FE_LIM, 32'h2710);
        rd(16'h0000, 32'h0, 1'b1);
        wr(ADR_SYM_RAMP, 32'h0);
        cyc(1);
        chk("acc", 32'h1, acc_o);
        rd(ADR_SYM_RAMP, 32'h4b);
        r = 32'h4b + $urandom % 32'h3e8;
        wr(ADR_SYM_RAMP, r);
        cyc(1);
        chk("dec", r * 32'ha, dec_o);
        wr(ADR_ACC, 32'h64);
        rd(ADR_SYM_RAMP, r);
        wr(ADR_ACC, 32'h2dc6c0);
        rd(ADR_SYM_RAMP, 32'hffff);
        $display("test ramps done");
        for (int m = 1; m <= 4; m++) begin
            mode = mode_type'(m);
            spd = 32'h3391 + $urandom % 32'h1388;
            cyc(2);
            chk("ref", 32'h3390, ref_o);
        end
        spd = 32'h64;
        wr(ADR_SPD_LIM, 32'h1e);
        rd(ADR_SPD_LIM, 32'h3c);
        chk("ref", 32'h3c, ref_o);
        stop = 1'b1;
        cyc(2);
        chk("dec", 32'h1770, dec_o);
        chk("qs", 32'h1, qs_o);
        stop = 1'b0;
        cls1 = 1'b1;
        wr(ADR_QS_DEC, 32'h64);
        cyc(1);
        chk("dec", 32'hc8, dec_o);
        cls1 = 1'b0;
        wr(ADR_SPD_SET, 32'h7918);
        wr(ADR_SPD_SRC, 32'h2);
        ceil = 16'sh3e8;
        rd(ADR_SPD_SET, 32'h7530);
        chk("sref", 32'h3e8, sref_o);
        wr(ADR_SPD_SET, 32'h86e8);
        rd(ADR_SPD_SET, 32'hffff8ad0);
        chk("sref", 32'hfffffc18, sref_o);
        wr(ADR_SPD_SRC, 32'h1);
        rd(ADR_SPD_SRC, 32'h2);
        wr(ADR_SPD_SRC, 32'h0);
        cyc(1);
        chk("sref", 32'h0, sref_o);
        $display("test speeds done");
        dev = 32'sh2711;
        for (int c = 3; c >= 0; c--) begin
            wr(ADR_FE_REACT, 32'(c));
            cyc(1);
            chk("class", (c == 0) ? 32'h1 : 32'(c), cls_o);
        end
        chk("fe", 32'h1, fe_o);
        dev = -32'sh2710;
        pos = 32'shc8;
        homed = 1'b1;
        cyc(2);
        chk("fe", 32'h0, fe_o);
        chk("lpos", 32'h0, lp_o);
        homed = 1'b0;
        wr(ADR_SL_POS, 32'h64);
        wr(ADR_SL_NEG, 32'hffffff9c);
        wr(ADR_SL_EN, 32'h3);
        cyc(1);
        chk("lpos", 32'h0, lp_o);
        homed = 1'b1;
        cyc(2);
        chk("lpos", 32'h1, lp_o);
        wr(ADR_SL_EN, 32'h2);
        pos = -32'shc8;
        cyc(2);
        chk("lneg", 32'h1, ln_o);
        wr(ADR_SL_EN, 32'h1);
        cyc(1);
        chk("lneg", 32'h0, ln_o);
        $display("test supervision done");
        dev = 32'sh5;
        wr(ADR_SS_DWELL, 32'h3);
        cyc(1);
        chk("stand", 32'h0, ss_o);
        wait_flag(1'b0);
        chk("stand", 32'h1, ss_o);
        wr(ADR_SS_DWELL, 32'h0);
        cyc(1);
        chk("stand", 32'h0, ss_o);
        dev = 32'sh14;
        wr(ADR_SS_TOUT, 32'h2);
        tgt = 1'b1;
        cyc(1);
        tgt = 1'b0;
        wait_flag(1'b1);
        rd(ADR_STATUS, 32'h1);
        wr(ADR_STATUS, 32'h1);
        cyc(1);
        chk("tout", 32'h0, to_o);
        pdone = 1'b1;
        cyc(1);
        pdone = 1'b0;
        wait_flag(1'b1);
        chk("tout", 32'h1, to_o);
        wr(ADR_STATUS, 32'h1);
        tgt = 1'b1;
        wr(ADR_SS_TOUT, 32'h0);
        cyc(40);
        chk("tout", 32'h0, to_o);
        $display("test standstill done");
        tally_and_finish();
    end
endmodule
